// File: include/flash_cmd_pkg.sv
// Purpose: shared constants for the serial flash command block
// Assumes: 40 MHz system clock, spi pins oversampled
// Notes: boot config layout is enable bit, delay byte, start address
package flash_cmd_pkg;
   localparam logic [7:0] OP_LATCH_SET = 8'h06;
   localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
   localparam logic [7:0] OP_CLEAR_STATUS = 8'h30;
   localparam logic [7:0] OP_ECC_READ = 8'h18;
   localparam logic [7:0] OP_BOOT_RD = 8'h14;
   localparam logic [7:0] OP_BOOT_WR = 8'h15;

   // status_reg_one bit positions, then the quad bit of configRegOne
   localparam int SR_WIP_BIT = 0;
   localparam int SR_WEL_BIT = 1;
   localparam int SR_EERR_BIT = 5;
   localparam int SR_PERR_BIT = 6;
   localparam int CFG_QUAD_BIT = 1;

   // boot_configuration fields
   localparam int BOOT_EN_BIT = 0;
   localparam int BOOT_DLY_LSB = 1;
   localparam int BOOT_DLY_MSB = 8;
   localparam int BOOT_ADDR_LSB = 9;
   localparam logic [31:0] BOOT_CFG_RESET = 32'h0000_0000;

   // bit counts on the serial side, then ecc repeat count and ecc address step
   localparam logic [5:0] OPCODE_BITS = 6'h08;
   localparam logic [5:0] ADDR_BITS = 6'h20;
   localparam logic [5:0] DUMMY_BITS = 6'h08;
   localparam logic [5:0] BOOT_DATA_BITS = 6'h20;
   localparam logic [5:0] CNT_SAT = 6'h3F;
   localparam logic [3:0] ECC_REPEAT_LAST = 4'hF;
   localparam logic [31:0] ECC_UNIT_STEP = 32'h0000_0010;

   // self-timed update of the boot register
   localparam int CLK_MHZ = 40;
   localparam int UPD_TIME_NS = 100000;
   localparam int UPD_CYCLES_INT = (UPD_TIME_NS * CLK_MHZ) / 1000;
   localparam logic [11:0] UPD_LAST = 12'(UPD_CYCLES_INT - 1);

   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 4;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_OPC = 4'h1,
      ST_ADDR = 4'h3,
      ST_DUMMY = 4'h2,
      ST_ECC = 4'h6,
      ST_BRD = 4'h7,
      ST_BWR = 4'h5,
      ST_BDLY = 4'h4,
      ST_BOOT = 4'hC,
      ST_SKIP = 4'hD
   } spi_state_e;
endpackage

// File: verilog/byte_fifo.sv
// Purpose: small synchronous fifo between array fetch and serial shifter
// Assumes: DEPTH is a power of two
// Notes: flush empties it at once; a push in the flush cycle is dropped
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic sysRst,
   input wire logic clkEn,
   input wire logic flush,
   input wire logic inValid,
   input wire logic [WIDTH-1:0] inData,
   output logic inReady,
   output logic outValid,
   output logic [WIDTH-1:0] outData,
   input wire logic outReady,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
   logic [AW:0] count, next_count;
   logic push, pop;

   assign inReady = (count != (AW+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData = mem[rdPtr];
   assign level = count;

   always_comb
   begin
      push = inValid & inReady;
      pop = outValid & outReady;
      next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
      next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk)
   begin
      if (sysRst || (clkEn && flush))
      begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end
      else if (clkEn)
      begin
         if (push)
            mem[wrPtr] <= inData;
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         count <= next_count;
      end
   end
endmodule

// File: verilog/flash_cmd_ctrl.sv
// Purpose: serial flash latch, status, ecc read and boot register commands
// Assumes: spi mode 0, sck well below clk/4, array answers within a byte time
// Notes: pins are oversampled; outputs change after a detected sck fall
`timescale 1ns/1ps
module flash_cmd_ctrl
   import flash_cmd_pkg::*;
(
   input wire logic clk,
   input wire logic sysRst,
   input wire logic clkEn,
   input wire logic csPin_n,
   input wire logic sckPin,
   input wire logic siPin,
   input wire logic dataLaneTwoPin,
   input wire logic [7:0] configRegOne,
   input wire logic srwdBit,
   input wire logic cmdReset,
   input wire logic [31:0] nvBootCfg,
   input wire logic eraseFail,
   input wire logic programFail,
   input wire logic arrValid,
   input wire logic [7:0] arrData,
   output logic arrReady,
   output logic [31:0] arrAddr,
   output logic arrEcc,
   output logic [3:0] dqOut,
   output logic [3:0] dqOe_n,
   output logic [7:0] statusRegOne,
   output logic [31:0] bootConfiguration,
   output logic nvWrite,
   output logic protectActive
);
   logic [2:0] csSy, sckSy;
   logic [1:0] siSy, laneSy;
   logic rise, fall, csUp, csLow, siBit;

   spi_state_e state, next_state;
   logic [5:0] bitCnt, next_bitCnt;
   logic [31:0] sh, next_sh;
   logic [4:0] brCnt, next_brCnt;
   logic [2:0] phase, next_phase;
   logic [3:0] rep, next_rep;
   logic [7:0] cur, next_cur;
   logic bootByte, next_bootByte;
   logic write_latch_flag, next_wel;
   logic eErr, next_eErr;
   logic pErr, next_pErr;
   logic updOn, next_updOn;
   logic [11:0] updCnt, next_updCnt;
   logic [31:0] updData, next_updData;
   logic bootPending, next_bootPending;
   logic armPending, next_armPending;
   logic fetchOn, next_fetchOn;
   logic [31:0] next_arrAddr, next_bootConfiguration;
   logic next_arrEcc, next_arrReady, next_nvWrite;
   logic [3:0] next_dqOut, next_dqOe_n;

   logic fifoFlush, fifoPop, fifoInReady, fifoOutValid, push, quad, lastPh;
   logic [7:0] fifoOut, newByte, byteNow;
   logic [2:0] fifoLevel;
   logic [31:0] bootStart;
   logic [7:0] bootDelay;
   logic inProgressFlag;

   // first stage feeds only the second; edges use stages two and three
   always_ff @(posedge clk)
   begin
      if (sysRst)
      begin
         csSy <= 3'h7;
         sckSy <= 3'h0;
         siSy <= 2'h0;
         laneSy <= 2'h3;
      end
      else if (clkEn)
      begin
         csSy <= {csSy[1:0], csPin_n};
         sckSy <= {sckSy[1:0], sckPin};
         siSy <= {siSy[0], siPin};
         laneSy <= {laneSy[0], dataLaneTwoPin};
      end
   end

   assign csLow = ~csSy[1];
   assign csUp = csSy[1] & ~csSy[2];
   assign rise = sckSy[1] & ~sckSy[2] & csLow;
   assign fall = ~sckSy[1] & sckSy[2] & csLow;
   assign siBit = siSy[1];
   assign quad = configRegOne[CFG_QUAD_BIT];
   assign push = arrValid & arrReady & fifoInReady;
   assign bootStart = {bootConfiguration[31:BOOT_ADDR_LSB], 9'h000};
   assign bootDelay = bootConfiguration[BOOT_DLY_MSB:BOOT_DLY_LSB];
   // an error keeps the part busy until clear status
   assign inProgressFlag = updOn | eErr | pErr;

   byte_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) fetchFifo (
      .clk(clk),
      .sysRst(sysRst),
      .clkEn(clkEn),
      .flush(fifoFlush),
      .inValid(push),
      .inData(arrData),
      .inReady(fifoInReady),
      .outValid(fifoOutValid),
      .outData(fifoOut),
      .outReady(fifoPop),
      .level(fifoLevel)
   );

   always_comb
   begin
      next_state = state;
      next_bitCnt = bitCnt;
      next_sh = sh;
      next_brCnt = brCnt;
      next_phase = phase;
      next_rep = rep;
      next_cur = cur;
      next_bootByte = bootByte;
      next_wel = write_latch_flag;
      next_eErr = eErr;
      next_pErr = pErr;
      next_updOn = updOn;
      next_updCnt = updCnt;
      next_updData = updData;
      next_bootPending = bootPending;
      next_armPending = armPending;
      next_fetchOn = fetchOn;
      next_arrAddr = push ? arrAddr + (arrEcc ? ECC_UNIT_STEP : 32'h0000_0001) : arrAddr;
      next_arrEcc = arrEcc;
      next_bootConfiguration = bootConfiguration;
      next_nvWrite = 1'b0;
      next_dqOut = dqOut;
      next_dqOe_n = dqOe_n;
      fifoFlush = 1'b0;
      fifoPop = 1'b0;
      newByte = {sh[6:0], siBit};
      lastPh = 1'b0;
      byteNow = cur;

      // self-timed boot register update
      if (updOn)
      begin
         next_updCnt = updCnt + 12'h001;
         if (updCnt == UPD_LAST)
         begin
            next_updOn = 1'b0;
            next_wel = 1'b0;
            next_eErr = eErr | eraseFail;
            next_pErr = pErr | programFail;
            if (!eraseFail && !programFail)
            begin
               next_bootConfiguration = updData;
               next_nvWrite = 1'b1;
            end
         end
      end

      if (armPending)
      begin
         // reset reloads the stored word and arms the boot read if its enable bit is set
         next_armPending = 1'b0;
         next_bootConfiguration = nvBootCfg;
         next_bootPending = nvBootCfg[BOOT_EN_BIT];
         next_fetchOn = nvBootCfg[BOOT_EN_BIT];
         next_arrAddr = {nvBootCfg[31:BOOT_ADDR_LSB], 9'h000};
         next_arrEcc = 1'b0;
         fifoFlush = 1'b1;
         next_state = ST_IDLE;
      end
      else if (csUp)
      begin
         case (state)
            ST_OPC:
               if (bitCnt == OPCODE_BITS)
               begin
                  if (sh[7:0] == OP_LATCH_SET)
                     next_wel = 1'b1;
                  else if (sh[7:0] == OP_LATCH_CLEAR && !inProgressFlag)
                     next_wel = 1'b0;
                  else if (sh[7:0] == OP_CLEAR_STATUS)
                  begin
                     // an error set in this same cycle survives
                     next_eErr = updOn && updCnt == UPD_LAST && eraseFail;
                     next_pErr = updOn && updCnt == UPD_LAST && programFail;
                  end
               end
            ST_BWR:
               if (bitCnt == BOOT_DATA_BITS && !updOn)
               begin
                  next_updOn = 1'b1;
                  next_updCnt = 12'h000;
                  next_updData = {sh[7:0], sh[15:8], sh[23:16], sh[31:24]};
               end
            ST_BOOT, ST_BDLY:
               if (bootByte)
                  next_bootPending = 1'b0;
            default:
            begin
            end
         endcase
         next_state = ST_IDLE;
         next_dqOe_n = 4'hF;
         fifoFlush = 1'b1;
         // a cut-short boot frame restarts from the start address
         next_fetchOn = (state == ST_BOOT || state == ST_BDLY) ? !bootByte : bootPending;
         next_arrEcc = 1'b0;
         next_arrAddr = bootStart;
      end
      else if (state == ST_IDLE)
      begin
         if (csLow)
         begin
            next_bitCnt = 6'h00;
            next_sh = 32'h0000_0000;
            next_phase = 3'h0;
            next_bootByte = 1'b0;
            if (bootPending)
               next_state = (bootDelay == 8'h00) ? ST_BOOT : ST_BDLY;
            else
               next_state = ST_OPC;
         end
      end
      else if (rise)
      begin
         if (bitCnt != CNT_SAT)
            next_bitCnt = bitCnt + 6'h01;
         case (state)
            ST_OPC:
            begin
               next_sh = {sh[30:0], siBit};
               if (bitCnt == OPCODE_BITS - 6'h01)
               begin
                  next_bitCnt = 6'h00;
                  if (newByte == OP_ECC_READ)
                     next_state = ST_ADDR;
                  else if (newByte == OP_BOOT_RD)
                  begin
                     next_state = ST_BRD;
                     next_brCnt = 5'h00;
                  end
                  else if (newByte == OP_BOOT_WR)
                     next_state = write_latch_flag ? ST_BWR : ST_SKIP;
                  else
                     next_bitCnt = OPCODE_BITS;
               end
            end
            ST_ADDR:
            begin
               next_sh = {sh[30:0], siBit};
               if (bitCnt == ADDR_BITS - 6'h01)
               begin
                  // low four address bits are forced to a unit boundary
                  next_arrAddr = {sh[30:3], 4'h0};
                  next_arrEcc = 1'b1;
                  next_fetchOn = 1'b1;
                  fifoFlush = 1'b1;
                  next_bitCnt = 6'h00;
                  next_state = ST_DUMMY;
               end
            end
            ST_DUMMY:
               if (bitCnt == DUMMY_BITS - 6'h01)
               begin
                  next_state = ST_ECC;
                  next_rep = 4'h0;
                  next_phase = 3'h0;
               end
            ST_BWR:
               next_sh = {sh[30:0], siBit};
            ST_BDLY:
            begin
               // sh counts delay rises; bitCnt saturates below the eight-bit range
               next_sh = sh + 32'h0000_0001;
               if (sh[7:0] == bootDelay - 8'h01)
                  next_state = ST_BOOT;
            end
            default:
            begin
            end
         endcase
      end
      else if (fall)
      begin
         case (state)
            ST_BRD:
            begin
               next_dqOe_n = 4'hD;
               next_dqOut = {2'h0, bootConfiguration[{brCnt[4:3], ~brCnt[2:0]}], 1'b0};
               next_brCnt = brCnt + 5'h01;
            end
            ST_ECC, ST_BOOT:
            begin
               lastPh = (state == ST_BOOT && quad);
               if (phase == 3'h0)
               begin
                  if (state == ST_BOOT || rep == 4'h0)
                  begin
                     byteNow = fifoOut;
                     fifoPop = fifoOutValid;
                  end
                  next_cur = byteNow;
                  if (state == ST_ECC)
                     next_rep = rep + 4'h1;
               end
               if (lastPh)
               begin
                  next_dqOe_n = 4'h0;
                  next_dqOut = phase[0] ? byteNow[3:0] : byteNow[7:4];
                  next_phase = {2'h0, ~phase[0]};
                  if (phase[0])
                     next_bootByte = 1'b1;
               end
               else
               begin
                  next_dqOe_n = 4'hD;
                  next_dqOut = {2'h0, byteNow[~phase], 1'b0};
                  next_phase = phase + 3'h1;
                  if (phase == 3'h7 && state == ST_BOOT)
                     next_bootByte = 1'b1;
               end
            end
            default:
            begin
            end
         endcase
      end

      if (cmdReset)
      begin
         next_armPending = 1'b1;
         next_state = ST_IDLE;
         next_dqOe_n = 4'hF;
      end
      next_arrReady = next_fetchOn && !fifoFlush
         && (fifoLevel + 3'(push) < 3'(FIFO_DEPTH));
   end

   always_ff @(posedge clk)
   begin
      if (sysRst)
      begin
         state <= ST_IDLE;
         bitCnt <= 6'h00;
         sh <= 32'h0000_0000;
         brCnt <= 5'h00;
         phase <= 3'h0;
         rep <= 4'h0;
         cur <= 8'h00;
         bootByte <= 1'b0;
         write_latch_flag <= 1'b0;
         eErr <= 1'b0;
         pErr <= 1'b0;
         updOn <= 1'b0;
         updCnt <= 12'h000;
         updData <= 32'h0000_0000;
         bootPending <= 1'b0;
         armPending <= 1'b1;
         fetchOn <= 1'b0;
         arrAddr <= 32'h0000_0000;
         arrEcc <= 1'b0;
         arrReady <= 1'b0;
         bootConfiguration <= BOOT_CFG_RESET;
         nvWrite <= 1'b0;
         dqOut <= 4'h0;
         dqOe_n <= 4'hF;
         statusRegOne <= 8'h00;
         protectActive <= 1'b0;
      end
      else if (clkEn)
      begin
         state <= next_state;
         bitCnt <= next_bitCnt;
         sh <= next_sh;
         brCnt <= next_brCnt;
         phase <= next_phase;
         rep <= next_rep;
         cur <= next_cur;
         bootByte <= next_bootByte;
         write_latch_flag <= next_wel;
         eErr <= next_eErr;
         pErr <= next_pErr;
         updOn <= next_updOn;
         updCnt <= next_updCnt;
         updData <= next_updData;
         bootPending <= next_bootPending;
         armPending <= next_armPending;
         fetchOn <= next_fetchOn;
         arrAddr <= next_arrAddr;
         arrEcc <= next_arrEcc;
         arrReady <= next_arrReady;
         bootConfiguration <= next_bootConfiguration;
         nvWrite <= next_nvWrite;
         dqOut <= next_dqOut;
         dqOe_n <= next_dqOe_n;
         statusRegOne <= {1'b0, next_pErr, next_eErr, 3'h0, next_wel,
            next_updOn | next_eErr | next_pErr};
         protectActive <= srwdBit & ~laneSy[1] & ~quad;
      end
   end
endmodule

// File: verification/flash_cmd_ctrl_assertions.sv
// Purpose: port-level checks on the serial flash command block
// Assumes: one clock domain, pins synchronised inside the block
// Notes: status latencies are given slack because the pins pass two sync flops
`timescale 1ns/1ps
module flash_cmd_ctrl_assertions
   import flash_cmd_pkg::*;
(
   input wire logic clk,
   input wire logic sysRst,
   input wire logic csPin_n,
   input wire logic dataLaneTwoPin,
   input wire logic [7:0] configRegOne,
   input wire logic srwdBit,
   input wire logic eraseFail,
   input wire logic programFail,
   input wire logic [31:0] arrAddr,
   input wire logic arrEcc,
   input wire logic [3:0] dqOe_n,
   input wire logic [7:0] statusRegOne,
   input wire logic nvWrite,
   input wire logic protectActive
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sysRst);

   reset_idle_a: assert property (disable iff (1'b0) sysRst |=>
      statusRegOne == 8'h00 && dqOe_n == 4'hF) else $error("outputs not idle after reset");
   latch_set_cs_a: assert property ((!csPin_n) [*8] |->
      !$rose(statusRegOne[SR_WEL_BIT])) else $error("latch set inside a frame");
   latch_clear_cs_a: assert property (((!csPin_n) [*8] ##0 !$past(statusRegOne[SR_WIP_BIT]))
      |-> !$fell(statusRegOne[SR_WEL_BIT])) else $error("latch cleared inside a frame");
   update_done_a: assert property (nvWrite |=> !nvWrite && !statusRegOne[SR_WEL_BIT]
      && !statusRegOne[SR_WIP_BIT]) else $error("update end flags wrong");
   error_busy_a: assert property ((statusRegOne[SR_EERR_BIT] || statusRegOne[SR_PERR_BIT])
      |-> statusRegOne[SR_WIP_BIT]) else $error("error flag without busy");
   erase_cause_a: assert property ($rose(statusRegOne[SR_EERR_BIT]) |-> $past(eraseFail))
      else $error("erase error without failure");
   program_cause_a: assert property ($rose(statusRegOne[SR_PERR_BIT]) |-> $past(programFail))
      else $error("program error without failure");
   ecc_align_a: assert property (arrEcc |-> arrAddr[3:0] == 4'h0)
      else $error("ecc unit address not aligned");
   quad_lanes_a: assert property (dqOe_n == 4'h0 |-> configRegOne[CFG_QUAD_BIT])
      else $error("four lanes driven in single mode");
   cs_release_a: assert property (csPin_n [*8] |-> dqOe_n == 4'hF)
      else $error("lanes still driven with chip select high");
   quad_unprot_a: assert property (configRegOne[CFG_QUAD_BIT] [*2] |-> !protectActive)
      else $error("protection active in quad mode");
   hw_protect_a: assert property ((srwdBit && !dataLaneTwoPin && !configRegOne[CFG_QUAD_BIT]) [*6]
      |-> protectActive) else $error("protection missing");

   cover property (nvWrite);
   cover property (dqOe_n == 4'h0);
   cover property ($rose(arrEcc));
endmodule

bind flash_cmd_ctrl flash_cmd_ctrl_assertions chk (.clk(clk), .sysRst(sysRst), .csPin_n(csPin_n),
   .dataLaneTwoPin(dataLaneTwoPin), .configRegOne(configRegOne), .srwdBit(srwdBit),
   .eraseFail(eraseFail), .programFail(programFail), .arrAddr(arrAddr), .arrEcc(arrEcc),
   .dqOe_n(dqOe_n), .statusRegOne(statusRegOne), .nvWrite(nvWrite), .protectActive(protectActive));

// File: verification/spi_host_model.sv
// Purpose: host controller model driving the serial pins in mode 0
// Assumes: sck high for six system clocks and low for seven, pins moved on clk fall
// Notes: si is inverted after each frame so a stale level never looks like data
`timescale 1ns/1ps
module spi_host_model
(
   input wire logic clk,
   input wire logic [3:0] dqOut,
   input wire logic [3:0] dqOe_n,
   output logic csPin_n,
   output logic sckPin,
   output logic siPin
);
   localparam int HALF = 6;

   initial
   begin
      csPin_n = 1'b1;
      sckPin = 1'b0;
      siPin = 1'b0;
   end

   // lanes are taken just before the rise, well after the device moved them
   task automatic cyc(input logic d, output logic [3:0] q);
      @(negedge clk);
      siPin = d;
      repeat (HALF) @(negedge clk);
      // an undriven lane reads as the inverse of its last value
      q = dqOut ^ dqOe_n;
      sckPin = 1'b1;
      repeat (HALF) @(negedge clk);
      sckPin = 1'b0;
   endtask

   task automatic start();
      @(negedge clk);
      csPin_n = 1'b0;
      repeat (HALF) @(negedge clk);
   endtask

   task automatic stop();
      repeat (2) @(negedge clk);
      csPin_n = 1'b1;
      siPin = ~siPin;
      repeat (10) @(negedge clk);
   endtask

   task automatic send(input logic [31:0] v, input int n);
      logic [3:0] q;
      for (int i = n - 1; i >= 0; i--)
         cyc(v[i], q);
   endtask

   task automatic recv(input logic quad, output logic [7:0] b);
      logic [3:0] q;
      b = 8'h00;
      for (int i = 0; i < (quad ? 2 : 8); i++)
      begin
         cyc(1'b0, q);
         b = quad ? {b[3:0], q} : {b[6:0], q[1]};
      end
   endtask
endmodule

// File: verification/flash_cmd_ctrl_tb_top.sv
// Purpose: self-checking bench for the serial flash command block
// Assumes: update time of UPD_CYCLES_INT clocks, host sck of thirteen clocks
// Notes: expected values come from a small model of the flags and boot word
`timescale 1ns/1ps
module flash_cmd_ctrl_tb_top
   import flash_cmd_pkg::*;
();
   logic clk, sysRst, clkEn, csPin_n, sckPin, siPin, dataLaneTwoPin, srwdBit, cmdReset;
   logic eraseFail, programFail, arrValid, arrReady, arrEcc, nvWrite, protectActive;
   logic write_latch_flag, eerr, perr, in_progress_flag;
   logic [3:0] dqOut, dqOe_n;
   logic [7:0] configRegOne, arrData, statusRegOne, b;
   logic [31:0] nvBootCfg, arrAddr, bootConfiguration, cfg, v, a;
   logic [7:0] expQ[$];
   int miscompares, num_checks, seed;

   flash_cmd_ctrl dut (.clk(clk), .sysRst(sysRst), .clkEn(clkEn), .csPin_n(csPin_n),
      .sckPin(sckPin), .siPin(siPin), .dataLaneTwoPin(dataLaneTwoPin),
      .configRegOne(configRegOne), .srwdBit(srwdBit), .cmdReset(cmdReset),
      .nvBootCfg(nvBootCfg), .eraseFail(eraseFail), .programFail(programFail),
      .arrValid(arrValid), .arrData(arrData), .arrReady(arrReady), .arrAddr(arrAddr),
      .arrEcc(arrEcc), .dqOut(dqOut), .dqOe_n(dqOe_n), .statusRegOne(statusRegOne),
      .bootConfiguration(bootConfiguration), .nvWrite(nvWrite), .protectActive(protectActive));
   spi_host_model host (.clk(clk), .dqOut(dqOut), .dqOe_n(dqOe_n), .csPin_n(csPin_n),
      .sckPin(sckPin), .siPin(siPin));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [7:0] datOf(input logic [31:0] x);
      return x[7:0] ^ x[15:8] ^ 8'h5A;
   endfunction
   function automatic logic [7:0] eccOf(input logic [31:0] x);
      return x[11:4] ^ 8'hC3;
   endfunction

   // array stalls at random so the fifo fills and drains unevenly
   always @(negedge clk)
   begin
      arrValid <= 1'($urandom_range(1));
      arrData <= arrEcc ? eccOf(arrAddr) : datOf(arrAddr);
   end
   // the store outside keeps the boot word across resets; reset loads the start word
   always @(posedge clk)
      if (sysRst)
         nvBootCfg <= cfg;
      else if (nvWrite)
         nvBootCfg <= bootConfiguration;

   task automatic chkR(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chkD(input string n, input logic [7:0] g);
      logic [7:0] e;
      e = expQ.pop_front();
      num_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chkSt();
      chkR("status", {24'h0, 1'b0, perr, eerr, 3'b000, write_latch_flag, in_progress_flag}, {24'h0, statusRegOne});
   endtask
   task automatic op(input logic [31:0] x, input int n);
      host.start();
      host.send(x, n);
      host.stop();
   endtask
   task automatic bootwr(input logic [31:0] x, input int n);
      host.start();
      host.send(32'(OP_BOOT_WR), 8);
      host.send({x[7:0], x[15:8], x[23:16], x[31:24]} >> (32 - n), n);
      host.stop();
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (90000) @(posedge clk);
      miscompares++;
      stop_test();
   end

   initial
   begin
      sysRst = 1'b1;
      clkEn = 1'b1;
      cmdReset = 1'b0;
      srwdBit = 1'b0;
      dataLaneTwoPin = 1'b1;
      configRegOne = 8'h00;
      eraseFail = 1'b0;
      programFail = 1'b0;
      seed = $urandom(32'h4E45);
      cfg = {23'($urandom), 8'($urandom_range(100, 60)), 1'b1};
      for (int q = 0; q < 2; q++)
      begin
         @(negedge clk);
         configRegOne = {6'($urandom), q[0], 1'b0};
         if (q == 0)
            repeat (10) @(negedge clk);
         else
            cmdReset = 1'b1;
         @(negedge clk);
         sysRst = 1'b0;
         cmdReset = 1'b0;
         repeat (8) @(negedge clk);
         chkR("boot word", cfg, bootConfiguration);
         host.start();
         repeat (int'(cfg[BOOT_DLY_MSB:BOOT_DLY_LSB])) host.send(32'h0, 1);
         for (int i = 0; i < 2; i++)
         begin
            expQ.push_back(datOf({cfg[31:9], 9'h000} + i));
            host.recv(q[0], b);
            chkD("boot data", b);
         end
         host.stop();
      end
      configRegOne[CFG_QUAD_BIT] = 1'b0;
      {write_latch_flag, eerr, perr, in_progress_flag} = 4'h0;
      op(32'(OP_LATCH_SET), 8);
      write_latch_flag = 1'b1;
      chkSt();
      op(32'(OP_LATCH_CLEAR >> 1), 7);
      chkSt();
      op(32'(OP_CLEAR_STATUS), 8);
      chkSt();
      op(32'(OP_LATCH_CLEAR), 8);
      write_latch_flag = 1'b0;
      chkSt();
      op({23'h0, OP_LATCH_SET, 1'b0}, 9);
      chkSt();
      // a frozen block must not see a frame at all
      clkEn = 1'b0;
      op(32'(OP_LATCH_SET), 8);
      clkEn = 1'b1;
      chkSt();
      bootwr($urandom, 32);
      chkSt();
      op(32'(OP_LATCH_SET), 8);
      write_latch_flag = 1'b1;
      bootwr($urandom, 31);
      chkSt();
      for (int f = 0; f < 3; f++)
      begin
         v = $urandom;
         op(32'(OP_LATCH_SET), 8);
         write_latch_flag = 1'b1;
         eraseFail = (f == 1);
         programFail = (f == 2);
         bootwr(v, 32);
         in_progress_flag = 1'b1;
         chkSt();
         op(32'(OP_LATCH_CLEAR), 8);
         chkSt();
         repeat (UPD_CYCLES_INT) @(negedge clk);
         eraseFail = 1'b0;
         programFail = 1'b0;
         if (f == 0)
            cfg = v;
         in_progress_flag = (f != 0);
         eerr = (f == 1);
         perr = (f == 2);
         chkR("boot word", cfg, bootConfiguration);
         chkR("flags", 32'({eerr, perr, in_progress_flag}), 32'({statusRegOne[SR_EERR_BIT],
            statusRegOne[SR_PERR_BIT], statusRegOne[SR_WIP_BIT]}));
         op(32'(OP_CLEAR_STATUS), 8);
         op(32'(OP_LATCH_CLEAR), 8);
         {write_latch_flag, eerr, perr, in_progress_flag} = 4'h0;
         chkSt();
      end
      host.start();
      host.send(32'(OP_BOOT_RD), 8);
      for (int i = 0; i < 8; i++)
      begin
         expQ.push_back(cfg[8 * (i % 4) +: 8]);
         host.recv(1'b0, b);
         chkD("boot reg read", b);
      end
      host.stop();
      a = {28'($urandom), 4'h0};
      host.start();
      host.send(32'(OP_ECC_READ), 8);
      host.send(a, 32);
      host.send(32'h0, 8);
      for (int i = 0; i < 17; i++)
      begin
         expQ.push_back(eccOf(a + 32'((i / 16) * 16)));
         host.recv(1'b0, b);
         chkD("ecc status", b);
      end
      host.stop();
      srwdBit = 1'b1;
      dataLaneTwoPin = 1'b0;
      for (int q = 0; q < 2; q++)
      begin
         configRegOne[CFG_QUAD_BIT] = q[0];
         repeat (8) @(negedge clk);
         chkR("protect", 32'(q == 0), 32'(protectActive));
      end
      stop_test();
   end
endmodule
